/* dv/tb.sv */
// self-checking bench for the pwm/carrier timer
// assumes count select 0 (one tick per core cycle), one interval pass at divide by four
`timescale 1ns/10ps
`default_nettype none
module tb;
   import tpc_pkg::*;
   logic       clk, rst_n, wr, rd, env, pin, oe, irq, stb;
   logic [7:0] addr, wdata, rdata, v;
   int         hi_len, lo_len, n_mismatch, n_tests, seed, n, m, lev;
   logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   tpc_timer i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .envelope_timer_irq_in(env), .timer_out_pin_out(pin), .timer_out_oe_out(oe),
      .match_irq_out(irq), .envelope_sync_strobe_out(stb));
   tpc_ir_load i_load (.core_clk_in(clk), .pin_in(pin), .oe_in(oe),
      .hi_len_out(hi_len), .lo_len_out(lo_len));
   // 25 MHz core clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic pin_is(input int cyc, input logic exp);
      repeat (cyc) @(posedge clk);
      @(negedge clk);
      chk(pin, exp);
   endtask
   // envelope pulse wide enough for the synchroniser, then settle time
   task automatic pulse_env();
      @(posedge clk);
      env <= 1'b1;
      repeat (6) @(posedge clk);
      chk(stb, 1'b1);
      env <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic stop_test();
      $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog, far beyond the 1300 or so cycles the tests need at most
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end
   initial begin
      seed = 62135;
      {wr, rd, env, addr, wdata, n_mismatch, n_tests} = '0;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ofs[i]) begin
         rreg(ofs[i], v);
         chk(v, 0);
      end
      wreg(TPC_COUNT_OFS, 8'h5a);
      rreg(TPC_COUNT_OFS, v);
      chk(v, 0);
      $display("test reset done");
      for (lev = 0; lev < 2; lev++) begin
         n = 1 + $unsigned($random(seed)) % 30;
         wreg(TPC_PERIOD_OFS, 8'(n));
         wreg(TPC_MODE_OFS, {1'b1, 3'(lev), TPC_MODE_INTERVAL, 1'(lev), 1'b1});
         repeat ((4 * n + 8) * (3 * lev + 1)) @(posedge clk);
         chk(16'(hi_len), 16'((n + 1) * (3 * lev + 1)));
         chk(16'(lo_len), 16'((n + 1) * (3 * lev + 1)));
         wreg(TPC_MODE_OFS, {1'b0, 3'(lev), TPC_MODE_INTERVAL, 1'(lev), 1'b1});
         pin_is(0, 1'(lev));
         rreg(TPC_COUNT_OFS, v);
         chk(v, 0);
      end
      $display("test interval done");
      n = 2 + $unsigned($random(seed)) % 30;
      m = $unsigned($random(seed)) % n;
      wreg(TPC_PERIOD_OFS, 8'(n));
      wreg(TPC_DUTY_OFS, 8'(m));
      wreg(TPC_MODE_OFS, {4'h8, TPC_MODE_PWM, 2'b01});
      repeat (3 * n + 8) @(posedge clk);
      chk(16'(hi_len), 16'(m + 1));
      chk(16'(lo_len), 16'(n - m));
      m = (m + 1) % n;
      wreg(TPC_DUTY_OFS, 8'(m));
      repeat (4 * n + 12) @(posedge clk);
      chk(16'(hi_len), 16'(m + 1));
      wreg(TPC_MODE_OFS, {4'h0, TPC_MODE_PWM, 2'b01});
      pin_is(0, 1'b0);
      $display("test pwm done");
      n = 1 + $unsigned($random(seed)) % 20;
      m = $unsigned($random(seed)) % 20;
      wreg(TPC_PERIOD_OFS, 8'(n));
      wreg(TPC_DUTY_OFS, 8'(m));
      wreg(TPC_CARRIER_OFS, 8'h06);
      rreg(TPC_CARRIER_OFS, v);
      chk(v, 8'h06);
      wreg(TPC_MODE_OFS, {4'h8, TPC_MODE_CARRIER, 2'b01});
      pin_is(2 * (n + m) + 8, 1'b0);
      pulse_env();
      rreg(TPC_CARRIER_OFS, v);
      chk(v, 8'h07);
      repeat (3 * (n + m) + 12) @(posedge clk);
      chk(16'(hi_len), 16'(m + 1));
      chk(16'(lo_len), 16'(n + 1));
      wreg(TPC_MODE_OFS, {4'h0, TPC_MODE_CARRIER, 2'b01});
      wreg(TPC_CARRIER_OFS, 8'h02);
      wreg(TPC_DUTY_OFS, 8'(m));
      wreg(TPC_MODE_OFS, {4'h8, TPC_MODE_CARRIER, 2'b01});
      pulse_env();
      pin_is(n + m + 4, 1'b1);
      wreg(TPC_CARRIER_OFS, 8'h00);
      pulse_env();
      rreg(TPC_CARRIER_OFS, v);
      chk(v, 8'h00);
      pin_is(0, 1'b0);
      $display("test carrier done");
      stop_test();
   end
endmodule
`default_nettype wire

/* dv/tpc_ir_load.sv */
// infrared load model: measures high and low widths seen on the timer pin
// assumes one clock; a disabled pin restarts the measurement
`timescale 1ns/10ps
`default_nettype none
module tpc_ir_load (
   // clock
   input  wire logic core_clk_in,
   // pin
   input  wire logic pin_in,
   input  wire logic oe_in,
   // last complete widths in core cycles
   output var int    hi_len_out,
   output var int    lo_len_out
);
   int   run_len = 0;
   logic last_q = 1'b0;
   // close a run at each pin edge; sampled on the falling clock so the pin has settled
   always @(negedge core_clk_in) begin
      if (oe_in !== 1'b1) begin
         run_len = 0;
      end else if (pin_in !== last_q) begin
         if (last_q) hi_len_out = run_len;
         else lo_len_out = run_len;
         run_len = 1;
      end else begin
         run_len = run_len + 1;
      end
      last_q = pin_in;
   end
endmodule
`default_nettype wire

/* dv/tpc_timer_properties.sv */
// port checker for the pwm/carrier timer, bound onto tpc_timer
// assumes software writes the mode register only through the register port
`timescale 1ns/10ps
`default_nettype none
module tpc_timer_check
   import tpc_pkg::*;
(
   // clock and reset
   input wire logic       core_clk_in,
   input wire logic       rst_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   // pins
   input wire logic       envelope_timer_irq_in,
   input wire logic       timer_out_pin_out,
   input wire logic       timer_out_oe_out,
   input wire logic       match_irq_out,
   input wire logic       envelope_sync_strobe_out
);
   logic       run_q;
   logic       env_q;
   logic       gap_ok_q;
   logic       mwr;
   logic [1:0] mode_q;
   logic [2:0] cks_q;
   logic [7:0] per_q;
   logic [9:0] gap_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   assign mwr = reg_wr_in && reg_addr_in == TPC_MODE_OFS;
   ////////////////////////////////////////////////////////////////////////////
   // shadow of mode and period as software wrote them
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         run_q <= 1'b0;
         mode_q <= 2'h0;
         cks_q <= 3'h0;
      end else if (mwr) begin
         run_q <= reg_wdata_in[TPC_RUN_BIT];
         mode_q <= reg_wdata_in[TPC_MODE_HI_BIT:TPC_MODE_LO_BIT];
         cks_q <= reg_wdata_in[TPC_CKS_HI_BIT:TPC_CKS_LO_BIT];
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) per_q <= 8'h00;
      else if (reg_wr_in && reg_addr_in == TPC_PERIOD_OFS) per_q <= reg_wdata_in;
   end
   // gap saturates so a long stop never wraps; each match pulse restarts it, a mode write clears gap_ok_q
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || mwr) gap_ok_q <= 1'b0;
      else if (match_irq_out) gap_ok_q <= 1'b1;
      if (!rst_n_in || match_irq_out) gap_q <= 10'h001;
      else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
   end
   // sticky: the envelope input has been high at least once
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) env_q <= 1'b0;
      else if (envelope_timer_irq_in) env_q <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not zero outside its slot");
   a_oe_follows: assert property (mwr |=> timer_out_oe_out == $past(reg_wdata_in[0]))
      else $error("output enable does not follow mode write");
   a_stop_quiet: assert property (mwr && !reg_wdata_in[TPC_RUN_BIT] |=>
      !match_irq_out && timer_out_pin_out == $past(reg_wdata_in[TPC_LEVEL_BIT]))
      else $error("stop did not restore default levels");
   a_idle_noirq: assert property (!run_q |-> !match_irq_out)
      else $error("match pulse while stopped");
   a_irq_spacing: assert property (match_irq_out && gap_ok_q && run_q &&
      cks_q == 3'h0 && mode_q != TPC_MODE_CARRIER |-> gap_q == {2'b00, per_q} + 10'h001)
      else $error("match pulse spacing wrong");
   a_out_toggles: assert property (match_irq_out && run_q && !mode_q |->
      timer_out_pin_out != $past(timer_out_pin_out) ||
      timer_out_pin_out != $past(timer_out_pin_out, 2))
      else $error("interval match without pin toggle");
   a_pwm_start_low: assert property (mwr && reg_wdata_in[TPC_RUN_BIT] &&
      reg_wdata_in[3:2] == TPC_MODE_PWM |=> timer_out_pin_out == $past(reg_wdata_in[1])
      ##1 timer_out_pin_out == $past(reg_wdata_in[1], 2))
      else $error("pwm start not held inactive");
   a_strobe_cause: assert property ($rose(envelope_sync_strobe_out) |-> env_q)
      else $error("transfer strobe without envelope input");
endmodule
bind tpc_timer tpc_timer_check i_chk (.core_clk_in, .rst_n_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .envelope_timer_irq_in,
   .timer_out_pin_out, .timer_out_oe_out, .match_irq_out, .envelope_sync_strobe_out);
`default_nettype wire

/* hw/tpc_count_tick.sv */
// count clock enable generator: one core cycle pulse per selected count period
// assumes the core clock is the prescaler source; selection is stable while running
`timescale 1ns/10ps
`default_nettype none
module tpc_count_tick (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // control
   input  wire logic       run_in,
   input  wire logic [2:0] select_in,
   // tick
   output logic            tick_out
);
   logic [11:0] div_q;
   logic [11:0] mask;

   // divider mask per selection; codes 4 and above fall back to the slowest core ratio
   always_comb begin
      case (select_in)
         3'h0:    mask = 12'h000;
         3'h1:    mask = 12'h003;
         3'h2:    mask = 12'h00f;
         3'h3:    mask = 12'h03f;
         default: mask = 12'hfff;
      endcase
   end

   // divider restarts with run so the first tick lands within one count period
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || !run_in) begin
         div_q <= 12'h000;
      end else begin
         div_q <= (div_q == mask) ? 12'h000 : div_q + 12'h001;
      end
   end

   assign tick_out = run_in && (div_q == mask);
endmodule
`default_nettype wire

/* hw/tpc_timer.sv */
// 8-bit compare timer with interval, pwm and infrared carrier output modes
// assumes envelope_timer_irq_in is asynchronous and wider than one count clock
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module tpc_timer (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic [7:0]      reg_rdata_out,
   // envelope timer
   input  wire logic       envelope_timer_irq_in,
   // outputs
   output logic            timer_out_pin_out,
   output logic            timer_out_oe_out,
   output logic            match_irq_out,
   output logic            envelope_sync_strobe_out
);
   import tpc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  mode_q;
   logic [7:0]  period_compare_q;
   logic [7:0]  duty_compare_q;
   logic [7:0]  duty_pending_q;
   logic        duty_pending_valid_q;
   logic [1:0]  duty_age_q;
   logic        remote_output_select_q;
   logic        gate_buffer_bit_q;
   logic        gate_active_bit_q;
   logic [7:0]  count_q;
   logic        started_q;
   tpc_cmp_type cmp_sel_q;
   logic        out_q;
   logic        irq_q;
   logic [7:0]  rdata_q;
   logic [2:0]  env_sync_q;
   logic        env_level_q;
   logic        strobe_q;
   logic [1:0]  gate_delay_q;
   logic        carrier_q;

   logic        count_run_enable;
   logic        idle_output_level;
   logic [1:0]  op_mode;
   logic [2:0]  count_clk_select;
   logic        tick;
   logic        wr_mode;
   logic        wr_period;
   logic        wr_duty;
   logic        wr_carrier;
   logic        period_hit;
   logic        duty_hit;
   logic        env_rise;

   assign count_run_enable  = mode_q[TPC_RUN_BIT];
   assign idle_output_level = mode_q[TPC_LEVEL_BIT];
   assign op_mode           = {mode_q[TPC_MODE_HI_BIT], mode_q[TPC_MODE_LO_BIT]};
   assign count_clk_select  = mode_q[TPC_CKS_HI_BIT:TPC_CKS_LO_BIT];

   // address decode
   assign wr_mode    = reg_wr_in && (reg_addr_in == TPC_MODE_OFS);
   assign wr_period  = reg_wr_in && (reg_addr_in == TPC_PERIOD_OFS);
   assign wr_duty    = reg_wr_in && (reg_addr_in == TPC_DUTY_OFS);
   assign wr_carrier = reg_wr_in && (reg_addr_in == TPC_CARRIER_OFS);

   ////////////////////////////////////////////////////////////////////////////
   // count clock enable
   tpc_count_tick u_tick (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .run_in      (count_run_enable),
      .select_in   (count_clk_select),
      .tick_out    (tick)
   );

   // mode register; software keeps other bits steady while running
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         mode_q <= TPC_MODE_RST;
      end else if (wr_mode) begin
         mode_q <= reg_wdata_in;
      end
   end

   // period compare; never rewritten in pwm/carrier while running
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         period_compare_q <= TPC_CMP_RST;
      end else if (wr_period) begin
         period_compare_q <= reg_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // duty compare with latched update while running
   // the written value waits in a shadow so the live compare never jumps mid-cycle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         duty_compare_q       <= TPC_CMP_RST;
         duty_pending_q       <= TPC_CMP_RST;
         duty_pending_valid_q <= 1'b0;
         duty_age_q           <= 2'h0;
      end else if (wr_duty) begin
         duty_pending_q       <= reg_wdata_in;
         duty_age_q           <= 2'h0;
         duty_pending_valid_q <= count_run_enable;
         if (!count_run_enable) begin
            duty_compare_q <= reg_wdata_in; // stopped: takes effect at once
         end
      end else if (duty_pending_valid_q && tick) begin
         if (duty_hit && duty_age_q == TPC_DUTY_SETTLE) begin
            duty_compare_q       <= duty_pending_q; // R10
            duty_pending_valid_q <= 1'b0;
         end else if (duty_age_q != TPC_DUTY_SETTLE) begin
            duty_age_q <= duty_age_q + 2'h1; // R10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // carrier control: select and gate buffer are software bits
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         remote_output_select_q <= TPC_CARRIER_RST[TPC_SELECT_BIT];
         gate_buffer_bit_q      <= TPC_CARRIER_RST[TPC_GATE_BUF_BIT];
      end else if (wr_carrier) begin
         remote_output_select_q <= reg_wdata_in[TPC_SELECT_BIT];
         gate_buffer_bit_q      <= reg_wdata_in[TPC_GATE_BUF_BIT]; // R16
      end
   end

   // envelope irq through three flops; a change counts once stages two and three agree
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         env_sync_q  <= 3'h0;
         env_level_q <= 1'b0;
      end else begin
         env_sync_q <= {env_sync_q[1:0], envelope_timer_irq_in}; // R17
         if (env_sync_q[1] == env_sync_q[2]) begin
            env_level_q <= env_sync_q[2];
         end
      end
   end

   // transfer strobe aligned to the count clock; driven out on envelope_sync_strobe_out, never an irq source
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         strobe_q <= 1'b0;
      end else if (tick) begin
         strobe_q <= env_level_q; // R17
      end
   end

   assign env_rise = tick && env_level_q && !strobe_q;

   // gate copy two count clocks after the strobe rises
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         gate_delay_q      <= 2'h0;
         gate_active_bit_q <= 1'b0;
      end else if (env_rise) begin
         gate_delay_q <= 2'h1;
      end else if (tick && gate_delay_q != 2'h0) begin
         if (gate_delay_q == TPC_GATE_DELAY) begin
            gate_active_bit_q <= gate_buffer_bit_q; // R18
            gate_delay_q      <= 2'h0;
         end else begin
            gate_delay_q <= gate_delay_q + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter and compare sequencing
   assign period_hit = (cmp_sel_q == TPC_CMP_PERIOD) && (count_q == period_compare_q);
   assign duty_hit   = (op_mode != TPC_MODE_INTERVAL) && (cmp_sel_q == TPC_CMP_DUTY)
                       && (count_q == duty_compare_q);

   // counter; pwm and carrier mask the first count clock after enable
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || !count_run_enable) begin
         count_q   <= 8'h00; // R20
         started_q <= 1'b0;
         cmp_sel_q <= TPC_CMP_PERIOD;
      end else if (tick) begin
         if (!started_q && op_mode != TPC_MODE_INTERVAL) begin
            started_q <= 1'b1; // R8
         end else if (period_hit) begin
            started_q <= 1'b1;
            count_q   <= 8'h00; // R2 R22 R7
            if (op_mode != TPC_MODE_INTERVAL) begin
               cmp_sel_q <= TPC_CMP_DUTY; // R5
            end
         end else if (duty_hit) begin
            cmp_sel_q <= TPC_CMP_PERIOD; // R6
            if (op_mode == TPC_MODE_CARRIER) begin
               count_q <= 8'h00; // R13
            end else begin
               count_q <= count_q + 8'h01; // R6
            end
         end else begin
            started_q <= 1'b1;
            count_q   <= count_q + 8'h01; // R1
         end
      end
   end

   // match irq: one core-cycle pulse on period match, or on any carrier match
   // a stop write clears it on its own edge so no late pulse follows the stop
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || !count_run_enable || (wr_mode && !reg_wdata_in[TPC_RUN_BIT])) begin
         irq_q <= 1'b0; // R3 R9
      end else begin
         irq_q <= tick && started_q && (period_hit ||
                  (duty_hit && op_mode == TPC_MODE_CARRIER)); // R2 R5 R6
      end
   end

   // wave level: toggle in interval, set/clear in pwm and carrier
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || !count_run_enable) begin
         out_q     <= 1'b0;
         carrier_q <= 1'b0;
      end else if (tick && started_q) begin
         case (op_mode)
            TPC_MODE_INTERVAL: begin
               if (period_hit) begin
                  out_q <= !out_q; // R2
               end
            end
            TPC_MODE_PWM: begin
               if (period_hit) begin
                  out_q <= 1'b1; // R5
               end else if (duty_hit) begin
                  out_q <= 1'b0; // R6
               end
            end
            TPC_MODE_CARRIER: begin
               if (period_hit) begin
                  carrier_q <= 1'b1; // R13
               end else if (duty_hit) begin
                  carrier_q <= 1'b0; // R13
               end
            end
            default: begin
               out_q <= out_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin: idle level sets the inactive polarity in every mode
   // trade-off: the carrier is gated directly by the active bit and run, so a gate close can cut it mid-high
   logic pin_level;
   always_comb begin
      pin_level = 1'b0;
      if (op_mode == TPC_MODE_CARRIER) begin
         if (!gate_active_bit_q || !count_run_enable) begin
            pin_level = 1'b0; // R15
         end else if (remote_output_select_q) begin
            pin_level = carrier_q; // R14 R15
         end else begin
            pin_level = 1'b1; // R15
         end
      end else begin
         pin_level = out_q && count_run_enable; // R3 R9
      end
   end

   assign timer_out_pin_out        = pin_level ^ idle_output_level; // R23 R3 R9
   assign timer_out_oe_out         = mode_q[TPC_OUT_EN_BIT];
   assign match_irq_out            = irq_q;
   assign envelope_sync_strobe_out = strobe_q;

   ////////////////////////////////////////////////////////////////////////////
   // read port: data in the cycle after the strobe, unmapped reads zero
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            TPC_MODE_OFS:    rdata_q <= mode_q;
            TPC_PERIOD_OFS:  rdata_q <= period_compare_q;
            TPC_DUTY_OFS:    rdata_q <= duty_compare_q;
            TPC_CARRIER_OFS: rdata_q <= {5'h00, remote_output_select_q,
                                         gate_buffer_bit_q, gate_active_bit_q};
            TPC_COUNT_OFS:   rdata_q <= count_q;
            default:         rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_out = rdata_q;
endmodule
`default_nettype wire

/* shared/tpc_pkg.sv */
// constants, register map and mode encodings for the pwm/carrier timer
// assumes a single core clock; the count clock arrives as a same-domain enable pulse
//
// Notes on behaviour
// R1: counting starts within one count clock of enable
// R2: interval match clears, toggles output, pulses irq
// R3: disable forces irq and output to default
// R4: software never rewrites period compare in pwm
// R5: pwm period match clears, irq, active, duty next
// R6: pwm duty match goes inactive, no clear
// R7: pwm cycle n+1, duty (m+1)/(n+1)
// R8: pwm start masks one count clock, inactive
// R9: pwm disable gives default irq, inactive output
// R10: duty write applied at old match, three clocks
// R11: software keeps duty below period, 8-bit
// R12: software rewrites duty compare before each restart
// R13: carrier: period low width, duty high width
// R14: carrier shown only while envelope gate open
// R15: gate 0 low; select picks high or carrier
// R16: gate bit double-buffered, active bit read-only
// R17: envelope irq synchronised into transfer strobe
// R18: gate copied two count clocks after strobe
// R19: software spaces gate buffer writes two clocks
// R20: disable stops and zeroes counter
// R21: mode bits unchanged while running
// R22: interval period is n+1 count clocks
// R23: idle output level follows software bit
package tpc_pkg;
   // register byte offsets
   localparam logic [7:0] TPC_MODE_OFS     = 8'h00;
   localparam logic [7:0] TPC_PERIOD_OFS   = 8'h04;
   localparam logic [7:0] TPC_DUTY_OFS     = 8'h08;
   localparam logic [7:0] TPC_CARRIER_OFS  = 8'h0c;
   localparam logic [7:0] TPC_COUNT_OFS    = 8'h10;
   // mode register fields
   localparam int TPC_RUN_BIT      = 7;
   localparam int TPC_CKS_HI_BIT   = 6;
   localparam int TPC_CKS_LO_BIT   = 4;
   localparam int TPC_MODE_HI_BIT  = 3;
   localparam int TPC_MODE_LO_BIT  = 2;
   localparam int TPC_LEVEL_BIT    = 1;
   localparam int TPC_OUT_EN_BIT   = 0;
   // carrier control fields
   localparam int TPC_SELECT_BIT   = 2;
   localparam int TPC_GATE_BUF_BIT = 1;
   localparam int TPC_GATE_ACT_BIT = 0;
   // reset values
   localparam logic [7:0] TPC_MODE_RST    = 8'h00;
   localparam logic [7:0] TPC_CMP_RST     = 8'h00;
   localparam logic [2:0] TPC_CARRIER_RST = 3'h0;
   // timing in count clocks
   localparam logic [1:0] TPC_DUTY_SETTLE = 2'h3;
   localparam logic [1:0] TPC_GATE_DELAY  = 2'h2;
   // operating modes
   localparam logic [1:0] TPC_MODE_INTERVAL = 2'h0;
   localparam logic [1:0] TPC_MODE_CARRIER  = 2'h1;
   localparam logic [1:0] TPC_MODE_PWM      = 2'h2;
   // which compare is armed
   typedef enum logic [1:0] {
      TPC_CMP_PERIOD = 2'b01,
      TPC_CMP_DUTY   = 2'b10
   } tpc_cmp_type;
endpackage
